// *** verilog/datu_top.sv ***
// Contract
// RULE_01 - area 2 is DRAM only when enabled
// RULE_02 - row address shifted 8 to 11 bits
// RULE_03 - width bit set means 8-bit, else 16-bit
// RULE_04 - 8-bit uses upper lane, 16-bit both
// RULE_05 - same splitting as basic bus space
// RULE_06 - 16-bit bytes by parity, longword as two words
// RULE_07 - select pin input until DRAM enabled
// RULE_08 - high write strobe acts as write enable
// RULE_09 - upper column strobe for upper byte or 8-bit
// RULE_10 - lower column strobe only 16-bit lower byte
// RULE_11 - read strobe acts as output enable
// RULE_12 - row then column on low address pins
// RULE_13 - precharge, row, two column states
// RULE_14 - column cycle bit gives three column states
// RULE_15 - early bit drops row strobe at row start
// RULE_16 - zero to three row hold states
// RULE_17 - always at least one precharge state
// RULE_18 - one to four precharge states
// RULE_19 - refresh uses same precharge count
// RULE_20 - only program waits, no wait input
// RULE_21 - three-state bit inserts 0 to 7 waits
// RULE_22 - two column strobes, one write enable
// RULE_23 - byte parity picks strobe, word uses both
// RULE_24 - otherwise row strobe falls mid row state
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
`include "datu_cfg.svh"
module datu_top
   import datu_pkg::*;
(
   input wire logic aclk, // system clock
   input wire logic aresetn, // sync reset
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic req_valid, // access request, held until done
   input wire logic req_write, // 1 write, 0 read
   input wire logic [1:0] req_size, // byte, word, longword
   input wire logic [23:0] req_addr, // byte address in area 2
   input wire logic [31:0] req_wdata, // right-justified write data
   output logic req_done, // access finished pulse
   output logic req_error, // area 2 not DRAM space
   output logic [31:0] req_rdata, // right-justified read data
   input wire logic refresh_req, // refresh precharge request
   output logic refresh_done, // refresh precharge finished
   output logic [15:0] dram_addr, // multiplexed address pins
   input wire logic [15:0] dram_data_in, // data pins in
   output logic [15:0] dram_data_out, // data pins out
   output logic [1:0] dram_data_oe, // lane drive, bit1 upper
   output logic row_strobe_n, // area 2 select pin out
   output logic area2_select_oe, // area 2 select pin drive
   output logic high_byte_write_strobe_n, // write enable
   output logic upper_column_strobe_n, // upper column strobe
   output logic lower_column_strobe_n, // lower column strobe
   output logic read_strobe_n // output enable
);
   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [15:0] datu_row_map(input logic [23:0] a, input logic [1:0] sh);
      logic [15:0] o;
      int idx;
      o = 16'h0000;
      for (int i = 0; i < 16; i++) begin
         idx = i + 8 + int'(sh);
         o[i] = (idx <= 23) ? a[idx] : a[i];
      end
      return o;
   endfunction : datu_row_map

   function automatic logic [1:0] datu_beats(input logic [1:0] sz, input logic w8);
      if (w8) begin
         return (sz == SZ_BYTE) ? 2'h0 : (sz == SZ_WORD) ? 2'h1 : 2'h3;
      end
      return (sz == SZ_LONG) ? 2'h1 : 2'h0;
   endfunction : datu_beats

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   logic [15:0] ctl_reg;
   logic [15:0] acc_reg;
   logic [15:0] bus_reg;
   logic [15:0] wait_reg;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [15:0] wr_val;
   logic [31:0] rd_val;
   logic rd_ok;
   datu_state_type state;

   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_val = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DATU_RESP_OK;
         aw_addr <= 8'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr inside {`DATU_OFS_CTL, `DATU_OFS_ACC, `DATU_OFS_BUS,
               `DATU_OFS_WAIT, `DATU_OFS_STAT}) ? `DATU_RESP_OK : `DATU_RESP_ERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // a partial strobe only touches the lanes it names; bits above 15 are never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_reg <= `DATU_RST_CTL;
         acc_reg <= `DATU_RST_ACC;
         bus_reg <= `DATU_RST_BUS;
         wait_reg <= `DATU_RST_WAIT;
      end else if (wr_fire) begin
         unique case (aw_addr)
            `DATU_OFS_CTL: ctl_reg <= (ctl_reg & ~{{8{w_strb[1]}}, {8{w_strb[0]}}})
               | (wr_val & `DATU_MSK_CTL);
            `DATU_OFS_ACC: acc_reg <= (acc_reg & ~{{8{w_strb[1]}}, {8{w_strb[0]}}})
               | (wr_val & `DATU_MSK_ACC);
            `DATU_OFS_BUS: bus_reg <= (bus_reg & ~{{8{w_strb[1]}}, {8{w_strb[0]}}})
               | (wr_val & `DATU_MSK_BUS);
            `DATU_OFS_WAIT: wait_reg <= (wait_reg & ~{{8{w_strb[1]}}, {8{w_strb[0]}}})
               | (wr_val & `DATU_MSK_WAIT);
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         `DATU_OFS_CTL: rd_val = {16'h0, ctl_reg};
         `DATU_OFS_ACC: rd_val = {16'h0, acc_reg};
         `DATU_OFS_BUS: rd_val = {16'h0, bus_reg};
         `DATU_OFS_WAIT: rd_val = {16'h0, wait_reg};
         `DATU_OFS_STAT: rd_val = {16'h0, state, 7'h00, state != S_IDLE};
         default: begin
            rd_val = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `DATU_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? `DATU_RESP_OK : `DATU_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // fields
   // ------------------------------------------------------------
   logic dse;
   logic column_cycle_length_bit;
   logic early_row_strobe_bit;
   logic w8;
   logic [1:0] tpc;
   logic [1:0] rcd;
   logic [2:0] waits;

   assign dse = ctl_reg[`DATU_CTL_DSE]; // see RULE_01
   assign column_cycle_length_bit = ctl_reg[`DATU_CTL_COLUMN_CYCLE_LENGTH_BIT];
   assign early_row_strobe_bit = ctl_reg[`DATU_CTL_EARLY_ROW_STROBE_BIT];
   assign w8 = bus_reg[`DATU_BUS_ABW]; // see RULE_03
   assign tpc = acc_reg[`DATU_ACC_TPC +: 2];
   assign rcd = acc_reg[`DATU_ACC_RCD +: 2];
   // waits come from the area setting only; there is no wait pin
   assign waits = bus_reg[`DATU_BUS_AST] ? wait_reg[`DATU_WAIT_CNT +: 3] : 3'h0; // see RULE_20

   // ------------------------------------------------------------
   // state sequencer
   // ------------------------------------------------------------
   logic phase;
   datu_state_type next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic fin;
   logic cur_refresh;
   logic [1:0] beats;

   // each bus state spans two clocks; phase marks its second half
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase <= 1'b0;
      end else begin
         phase <= !phase;
      end
   end

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      fin = 1'b0;
      if (phase) begin
         unique case (state)
            S_IDLE: begin
               if ((refresh_req && !refresh_done) || (req_valid && !req_done && dse)) begin
                  next_state = S_PRE; // see RULE_17
                  next_cnt = {1'b0, tpc}; // see RULE_18
               end
            end
            S_PRE: begin
               if (cnt != 3'h0) begin
                  next_cnt = cnt - 3'h1;
               end else if (cur_refresh) begin
                  next_state = S_IDLE; // see RULE_19
                  fin = 1'b1;
               end else begin
                  next_state = S_ROW; // see RULE_13
               end
            end
            S_ROW: begin
               if (rcd != 2'h0) begin
                  next_state = S_RHOLD; // see RULE_16
                  next_cnt = {1'b0, rcd} - 3'h1;
               end else begin
                  next_state = S_COL1;
               end
            end
            S_RHOLD: begin
               if (cnt != 3'h0) begin
                  next_cnt = cnt - 3'h1;
               end else begin
                  next_state = S_COL1;
               end
            end
            S_COL1: begin
               if (waits != 3'h0) begin
                  next_state = S_WAIT; // see RULE_21
                  next_cnt = waits - 3'h1;
               end else begin
                  next_state = S_COL2;
               end
            end
            S_WAIT: begin
               if (cnt != 3'h0) begin
                  next_cnt = cnt - 3'h1;
               end else begin
                  next_state = S_COL2;
               end
            end
            S_COL2: begin
               if (column_cycle_length_bit) begin
                  next_state = S_COL3; // see RULE_14
               end else begin
                  next_state = (beats == 2'h0) ? S_IDLE : S_PRE;
                  next_cnt = {1'b0, tpc};
                  fin = 1'b1;
               end
            end
            S_COL3: begin
               next_state = (beats == 2'h0) ? S_IDLE : S_PRE;
               next_cnt = {1'b0, tpc};
               fin = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= S_IDLE;
         cnt <= 3'h0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
      end
   end

   // ------------------------------------------------------------
   // access splitting and data alignment
   // ------------------------------------------------------------
   logic [23:0] cur_addr;
   logic cur_write;
   logic [1:0] cur_size;
   logic [31:0] wsh;
   logic [31:0] rsh;
   logic [31:0] next_rsh;
   logic narrow;
   logic [1:0] lane;
   logic [7:0] rbyte;

   assign narrow = w8 || cur_size == SZ_BYTE;
   // even byte on the upper lane, odd on the lower; 8-bit space only upper
   assign lane = w8 ? 2'b10 : (cur_size != SZ_BYTE) ? 2'b11
      : cur_addr[0] ? 2'b01 : 2'b10; // see RULE_06, RULE_04
   assign rbyte = lane[1] ? dram_data_in[15:8] : dram_data_in[7:0];
   assign next_rsh = narrow ? {rsh[23:0], rbyte} : {rsh[15:0], dram_data_in};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_done <= 1'b0;
         req_error <= 1'b0;
         req_rdata <= 32'h0;
         refresh_done <= 1'b0;
         cur_refresh <= 1'b0;
         cur_addr <= 24'h0;
         cur_write <= 1'b0;
         cur_size <= SZ_BYTE;
         beats <= 2'h0;
         wsh <= 32'h0;
         rsh <= 32'h0;
      end else begin
         req_done <= 1'b0;
         req_error <= 1'b0;
         refresh_done <= 1'b0;
         if (phase && state == S_IDLE) begin
            if (refresh_req && !refresh_done) begin
               cur_refresh <= 1'b1;
            end else if (req_valid && !req_done) begin
               if (!dse) begin
                  req_done <= 1'b1; // see RULE_01
                  req_error <= 1'b1;
               end else begin
                  cur_addr <= req_addr;
                  cur_write <= req_write;
                  cur_size <= req_size;
                  beats <= datu_beats(req_size, w8); // see RULE_05
                  wsh <= (req_size == SZ_LONG) ? req_wdata
                     : (req_size == SZ_WORD) ? {req_wdata[15:0], 16'h0}
                     : {req_wdata[7:0], 24'h0};
                  rsh <= 32'h0;
               end
            end
         end
         if (fin && cur_refresh) begin
            refresh_done <= 1'b1;
            cur_refresh <= 1'b0;
         end else if (fin) begin
            if (!cur_write) begin
               rsh <= next_rsh;
            end
            if (beats == 2'h0) begin
               req_done <= 1'b1;
               req_rdata <= cur_write ? 32'h0 : next_rsh;
            end else begin
               beats <= beats - 2'h1; // see RULE_06
               cur_addr <= cur_addr + (narrow ? 24'h1 : 24'h2);
               wsh <= narrow ? {wsh[23:0], 8'h00} : {wsh[15:0], 16'h0};
            end
         end
      end
   end

   // ------------------------------------------------------------
   // pins; each follows the state one clock later, so relative timing holds
   // ------------------------------------------------------------
   logic in_col;
   logic ras_on;
   logic cas_on;

   assign in_col = state inside {S_COL1, S_WAIT, S_COL2, S_COL3};
   assign ras_on = !cur_refresh && ((state == S_ROW && (early_row_strobe_bit || phase))
      || state == S_RHOLD || in_col); // see RULE_15, RULE_24
   // reads open the column strobe early so waits stretch it; writes hold it
   // back so waits stretch data setup instead
   assign cas_on = cur_write ? (state inside {S_COL2, S_COL3})
      : ((state == S_COL1 && phase) || state inside {S_WAIT, S_COL2, S_COL3}); // see RULE_20

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dram_addr <= 16'h0;
         dram_data_out <= 16'h0;
         dram_data_oe <= 2'b00;
         row_strobe_n <= 1'b1;
         area2_select_oe <= 1'b0;
         high_byte_write_strobe_n <= 1'b1;
         upper_column_strobe_n <= 1'b1;
         lower_column_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
      end else begin
         area2_select_oe <= dse; // see RULE_07
         row_strobe_n <= !ras_on;
         // the row goes out in precharge already, so it is set up before the row strobe falls
         if (state inside {S_ROW, S_RHOLD} || (state == S_PRE && !cur_refresh)) begin
            dram_addr <= datu_row_map(cur_addr, ctl_reg[`DATU_CTL_MXC +: 2]); // see RULE_02
         end else if (in_col) begin
            dram_addr <= cur_addr[15:0]; // see RULE_12
         end
         upper_column_strobe_n <= !(cas_on && lane[1]); // see RULE_09, RULE_23
         lower_column_strobe_n <= !(cas_on && lane[0]); // see RULE_10, RULE_22
         high_byte_write_strobe_n <= !(in_col && cur_write); // see RULE_08, RULE_22
         read_strobe_n <= !(in_col && !cur_write); // see RULE_11
         dram_data_oe <= {2{in_col && cur_write}} & lane; // see RULE_04
         dram_data_out <= narrow ? {wsh[31:24], wsh[31:24]} : wsh[31:16];
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [4:0] pre_clks;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_clks <= 5'h0;
      end else begin
         pre_clks <= (state == S_PRE) ? pre_clks + 5'h1 : 5'h0;
      end
   end

   a_early_row_fall: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_15
      (state == S_ROW && !phase && early_row_strobe_bit) |=> !row_strobe_n)
      else $error("row strobe not low at row state start");
   a_late_row_fall: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_24
      (state == S_ROW && !phase && !early_row_strobe_bit) |=> row_strobe_n ##1 !row_strobe_n)
      else $error("row strobe not falling mid row state");
   a_select_input: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_07
      (!dse && !$past(dse)) |-> !area2_select_oe)
      else $error("select pin driven without DRAM space");
   a_row_after_pre: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_17
      $rose(state == S_ROW) |-> $past(state) == S_PRE)
      else $error("row state not preceded by precharge");
   a_hold_keeps_row: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_16
      (state == S_RHOLD && $past(state) == S_RHOLD) |=> $stable(dram_addr))
      else $error("row address moved during row hold");
   a_no_lower_cas: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_10
      (w8 && $past(w8)) |-> lower_column_strobe_n)
      else $error("lower column strobe in 8-bit space");
   a_no_oe_write: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_11
      (in_col && cur_write) |=> read_strobe_n && !high_byte_write_strobe_n)
      else $error("output enable active during write");
   a_pre_length: assert property (@(posedge aclk) disable iff (!aresetn) // see RULE_18
      $fell(state == S_PRE) |-> pre_clks == 5'(({3'h0, tpc} + 5'h1) * `DATU_STATE_CLKS))
      else $error("precharge length differs from setting");
endmodule : datu_top

// *** verilog/datu_cfg.svh ***
`ifndef DATU_CFG_SVH
`define DATU_CFG_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define DATU_OFS_CTL 8'h00
`define DATU_OFS_ACC 8'h04
`define DATU_OFS_BUS 8'h08
`define DATU_OFS_WAIT 8'h0C
`define DATU_OFS_STAT 8'h10
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define DATU_CTL_DSE 0
`define DATU_CTL_MXC 4
`define DATU_CTL_COLUMN_CYCLE_LENGTH_BIT 8
`define DATU_CTL_EARLY_ROW_STROBE_BIT 9
`define DATU_ACC_TPC 0
`define DATU_ACC_RCD 4
`define DATU_BUS_ABW 0
`define DATU_BUS_AST 1
`define DATU_WAIT_CNT 0
// ------------------------------------------------------------
// writable bits and reset values
// ------------------------------------------------------------
`define DATU_MSK_CTL 16'h0371
`define DATU_MSK_ACC 16'h0033
`define DATU_MSK_BUS 16'h0003
`define DATU_MSK_WAIT 16'h0007
`define DATU_RST_CTL 16'h0000
`define DATU_RST_ACC 16'h0000
`define DATU_RST_BUS 16'h0002
`define DATU_RST_WAIT 16'h0007
// ------------------------------------------------------------
// timing: clocks per bus state
// ------------------------------------------------------------
`define DATU_STATE_CLKS 2
`define DATU_RESP_OK 2'h0
`define DATU_RESP_ERR 2'h2
`endif

// *** verilog/datu_pkg.sv ***
package datu_pkg;
   typedef enum logic [7:0] {
      S_IDLE  = 8'h01,
      S_PRE   = 8'h02,
      S_ROW   = 8'h04,
      S_RHOLD = 8'h08,
      S_COL1  = 8'h10,
      S_WAIT  = 8'h20,
      S_COL2  = 8'h40,
      S_COL3  = 8'h80
   } datu_state_type;
   typedef enum logic [1:0] {
      SZ_BYTE = 2'h0,
      SZ_WORD = 2'h1,
      SZ_LONG = 2'h2
   } datu_size_type;
endpackage : datu_pkg

// *** testbench/datu_dram_model.sv ***
`timescale 1ns/100ps
module datu_dram_model (
   input wire logic [15:0] addr, // address pins
   input wire logic [15:0] din, // data from controller
   input wire logic ras_n, // row strobe
   input wire logic we_n, // write enable
   input wire logic up_cs_n, // upper column strobe
   input wire logic lo_cs_n, // lower column strobe
   input wire logic oe_n, // output enable
   output logic [15:0] dout // data to controller
);
   logic [15:0] row;
   logic [15:0] last = 16'h0000;
   logic [7:0] hi [logic [31:0]];
   logic [7:0] lo [logic [31:0]];
   always @(negedge ras_n) row = addr;
   always @(negedge up_cs_n) if (!we_n) hi[{row, addr}] = din[15:8];
   always @(negedge lo_cs_n) if (!we_n) lo[{row, addr}] = din[7:0];
   // a released bus shows the inverse of its last value, so a stale sample cannot match
   always @* begin
      if (!oe_n && !(up_cs_n && lo_cs_n)) begin
         dout = {hi[{row, addr}], lo[{row, addr}]};
         last = dout;
      end else begin
         dout = ~last;
      end
   end
endmodule : datu_dram_model

// *** testbench/testbench.sv ***
`timescale 1ns/100ps
`include "datu_cfg.svh"
module testbench;
   typedef struct packed {
      logic w8, ast, column_cycle_length_bit, early;
      logic [2:0] wc, mx;
      logic [1:0] tpc, rcd, sz;
      logic [23:0] a;
      logic [31:0] d;
   } datu_row_type;
   datu_row_type rows [7] = '{
      '{1'h0,1'h0,1'h0,1'h0,3'h0,3'h0,2'h0,2'h0,2'h1,24'h345670,32'h0000A5C3},
      '{1'h0,1'h0,1'h1,1'h1,3'h0,3'h1,2'h1,2'h1,2'h0,24'h5A1240,32'h0000003C},
      '{1'h0,1'h1,1'h0,1'h0,3'h3,3'h2,2'h2,2'h2,2'h0,24'h7E0031,32'h000000C5},
      '{1'h0,1'h1,1'h1,1'h0,3'h7,3'h3,2'h3,2'h3,2'h2,24'h0F8104,32'h89ABCDEF},
      '{1'h1,1'h0,1'h0,1'h1,3'h0,3'h0,2'h0,2'h0,2'h1,24'h222220,32'h00001E2D},
      '{1'h1,1'h1,1'h0,1'h0,3'h1,3'h4,2'h1,2'h0,2'h2,24'h400008,32'h0F1E2D3C},
      '{1'h1,1'h0,1'h1,1'h0,3'h0,3'h2,2'h0,2'h1,2'h0,24'h000013,32'h0000005A}};
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, req_wdata = 32'h0, req_rdata, rd, rq;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, req_valid = 1'h0, req_write = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, dram_data_oe, rs, req_size = 2'h0, oe_cap;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic refresh_req = 1'h0, req_done, req_error, refresh_done, er;
   logic [23:0] req_addr = 24'h0;
   logic [15:0] dram_addr, dram_data_in, dram_data_out, row_cap, col_cap;
   logic row_strobe_n, area2_select_oe, high_byte_write_strobe_n, upper_column_strobe_n;
   logic lower_column_strobe_n, read_strobe_n, ras_pin;
   int error_cnt = 0, checked = 0, rs_low, uf, lf, wef, oef, cyc, i, n;
   int bt, wt, st, per, lastv, s, m;
   datu_row_type r;
   datu_top i_dut (.*);
   // the select pin floats to its pull-up until the design drives it
   assign ras_pin = area2_select_oe ? row_strobe_n : 1'h1;
   datu_dram_model i_mem (.addr(dram_addr), .din(dram_data_out), .ras_n(ras_pin),
      .we_n(high_byte_write_strobe_n), .up_cs_n(upper_column_strobe_n),
      .lo_cs_n(lower_column_strobe_n), .oe_n(read_strobe_n), .dout(dram_data_in));
   always #10 aclk = ~aclk;
   always @(negedge aclk) if (!ras_pin) rs_low++;
   always @(negedge ras_pin) row_cap = dram_addr;
   always @(negedge upper_column_strobe_n) uf++;
   always @(negedge lower_column_strobe_n) lf++;
   always @(negedge high_byte_write_strobe_n) wef++;
   always @(negedge read_strobe_n) oef++;
   always @(negedge upper_column_strobe_n or negedge lower_column_strobe_n) begin
      col_cap = dram_addr;
      if (!high_byte_write_strobe_n) oe_cap = dram_data_oe;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // bready and rready stay high once raised; only the watchdog ends a wait
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : axr
   task automatic acc(input logic w, input logic [1:0] sz, input logic [23:0] a,
      input logic [31:0] d);
      rs_low = 0;
      uf = 0;
      lf = 0;
      wef = 0;
      oef = 0;
      cyc = 0;
      req_write <= w;
      req_size <= sz;
      req_addr <= a;
      req_wdata <= d;
      req_valid <= 1'h1;
      do begin
         @(posedge aclk);
         cyc++;
      end while (!req_done);
      req_valid <= 1'h0;
      er = req_error;
      rq = req_rdata;
      // let an edge pass so a following call never raises valid in the same step
      @(posedge aclk);
   endtask : acc
   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   initial begin
      #(20 * 20000);
      error_cnt++;
      end_of_test;
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      for (i = 0; i < 7; i++) begin
         r = rows[i];
         axw(`DATU_OFS_CTL, {22'h0, r.early, r.column_cycle_length_bit, 1'h0, r.mx, 3'h0, 1'h1});
         axw(`DATU_OFS_ACC, {26'h0, r.rcd, 2'h0, r.tpc});
         axw(`DATU_OFS_BUS, {30'h0, r.ast, r.w8});
         axw(`DATU_OFS_WAIT, {29'h0, r.wc});
         bt = r.w8 ? (1 << r.sz) : (r.sz == 2'h2 ? 2 : 1);
         lastv = r.a + (bt - 1) * (r.w8 ? 1 : 2);
         wt = r.ast ? r.wc : 0;
         st = r.tpc + r.rcd + wt + r.column_cycle_length_bit + 4;
         per = 2 * (r.rcd + wt + 2 + r.column_cycle_length_bit) + (r.early ? 2 : 1);
         s = 8 + r.mx[1:0];
         m = (1 << (24 - s)) - 1;
         acc(1'h1, r.sz, r.a, r.d);
         chk(wef, bt);
         chk(oef, 0);
         acc(1'h0, r.sz, r.a, 32'h0);
         chk(rq, r.d & ~(32'hFFFFFFFF << (8 << r.sz)));
         chk(oef, bt);
         chk(wef, 32'h0);
         chk(uf, r.w8 ? bt : (r.sz == 2'h0 ? !r.a[0] : bt));
         chk(lf, r.w8 ? 0 : (r.sz == 2'h0 ? r.a[0] : bt));
         chk(rs_low, bt * per);
         chk(row_cap, ((lastv >> s) & m) | (lastv & ~m & 32'hFFFF));
         chk(col_cap, lastv & 32'hFFFF);
         chk(oe_cap, (r.w8 || r.sz == 2'h0 && !r.a[0]) ? 2 : r.sz == 2'h0 ? 1 : 3);
         if (bt == 1) chk(cyc == 2 * st + 2 || cyc == 2 * st + 3, 32'h1);
         $display("row %0d done", i);
      end
      chk(area2_select_oe, 32'h1);
      axw(`DATU_OFS_ACC, 32'h2);
      uf = 0;
      lf = 0;
      n = 0;
      refresh_req <= 1'h1;
      do begin
         @(posedge aclk);
         n++;
      end while (!refresh_done);
      refresh_req <= 1'h0;
      chk(n == 8 || n == 9, 32'h1);
      chk(uf + lf, 32'h0);
      $display("refresh test done");
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk(area2_select_oe, 32'h0);
      axr(`DATU_OFS_BUS);
      chk(rd, 32'h2);
      axr(`DATU_OFS_WAIT);
      chk(rd, 32'h7);
      axr(8'h40);
      chk(rs, 32'h2);
      acc(1'h0, 2'h1, 24'h000010, 32'h0);
      chk(er, 32'h1);
      chk(rs_low, 32'h0);
      $display("reset and refusal tests done");
      end_of_test;
   end
endmodule : testbench
